//--- src/tx_test_pattern_ctrl.sv
// transmit test pattern, transmit disable, power-down and link self test control
`timescale 1ns/100ps
// Notes on behaviour
// - test mode one sends +1, -1 alternating forever
// - test mode two sends ten +1 then ten -1, repeating
// - test mode three transmits normally as leader with idle symbols only
// - transmit disable keeps paths running but sends zero symbols only
// - test modes change only transmitted symbol values, nothing else
// - mode select is bits 15:13; 001, 010, 011 select modes one to three
// - device raises power-down ready once down; host polls it
// - clearing power-down request makes device run the selected mode
// - remote loopback returns line-received frames back over the cable
// - local side transmits generator frames and checks looped frames
// - with remote loopback and rx suppress both set, line data is not forwarded to the mac
module tx_test_pattern_ctrl
  import tx_test_pkg::*;
#(
  parameter int SYM_DIVIDE = SYM_DIV,
  parameter int PD_CYCLES = PD_SETTLE_CYC
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // test mode control register port
  input wire logic tm_ctrl_wr_i,
  input wire logic [15:0] tm_ctrl_wdata_i,
  output logic [15:0] tm_ctrl_rdata_o,
  // loose configuration and status bits
  input wire logic soft_powerdown_request_i,
  output logic soft_powerdown_ready_o,
  input wire logic autoneg_enable_bit_i,
  input wire logic forced_link_enable_i,
  input wire logic tx_disable_enable_i,
  input wire logic remote_loopback_enable_i,
  input wire logic remote_loopback_rx_suppress_i,
  input wire logic diag_clock_enable_i,
  input wire logic frame_gen_enable_i,
  input wire logic frame_check_enable_i,
  // normal transmit symbol stream from the pcs
  input wire logic [1:0] pcs_tx_sym_i,
  input wire logic [1:0] pcs_idle_sym_i,
  // mac interface nibbles
  input wire logic mac_tx_en_i,
  input wire logic [3:0] mac_txd_i,
  output logic mac_rx_dv_o,
  output logic [3:0] mac_rxd_o,
  // line side nibbles from and to the pcs
  input wire logic line_rx_dv_i,
  input wire logic [3:0] line_rxd_i,
  output logic line_tx_en_o,
  output logic [3:0] line_txd_o,
  // transmitter symbols
  output logic [1:0] tx_sym_o,
  output logic tx_sym_stb_o,
  output logic tx_active_o,
  // frame checker results
  output logic [15:0] fc_frame_cnt_o,
  output logic [15:0] fc_err_cnt_o
);

  ////////////////////////////////////////////////////////////////////////////
  // register and applied configuration

  logic [15:0] tm_ctrl_q;
  tm_sel_t mode_q;
  logic txdis_q;
  pd_state_t pd_q;
  logic [15:0] pd_cnt_q;
  logic forced_q;

  function automatic tm_sel_t decode_sel(input logic [15:0] r);
    case (r[TM_SEL_HI:TM_SEL_LO])
      TM_ONE: decode_sel = TM_ONE;
      TM_TWO: decode_sel = TM_TWO;
      TM_THREE: decode_sel = TM_THREE;
      default: decode_sel = TM_NORMAL;
    endcase
  endfunction

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      tm_ctrl_q <= TM_CTRL_RESET;
    end else if (tm_ctrl_wr_i) begin
      tm_ctrl_q <= tm_ctrl_wdata_i & TM_CTRL_MASK;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      tm_ctrl_rdata_o <= TM_CTRL_RESET;
    end else begin
      tm_ctrl_rdata_o <= tm_ctrl_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software power-down sequencer

  // the pattern engine only picks up new settings on the way out of
  // power-down, so a half-written configuration never reaches the line
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pd_q <= PD_RUN;
      pd_cnt_q <= 16'h0000;
      mode_q <= TM_NORMAL;
      txdis_q <= 1'b0;
      forced_q <= 1'b0;
    end else begin
      case (pd_q)
        PD_RUN: begin
          if (soft_powerdown_request_i) begin
            pd_q <= PD_ENTER;
            pd_cnt_q <= 16'h0000;
          end
        end
        PD_ENTER: begin
          if (!soft_powerdown_request_i) begin
            pd_q <= PD_RUN;
          end else if (pd_cnt_q >= 16'(PD_CYCLES - 1)) begin
            pd_q <= PD_DOWN;
          end else begin
            pd_cnt_q <= pd_cnt_q + 16'h0001;
          end
        end
        PD_DOWN: begin
          if (!soft_powerdown_request_i) begin
            pd_q <= PD_RUN;
            mode_q <= decode_sel(tm_ctrl_q);
            txdis_q <= tx_disable_enable_i;
            forced_q <= forced_link_enable_i && !autoneg_enable_bit_i;
          end
        end
        default: pd_q <= PD_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      soft_powerdown_ready_o <= 1'b0;
    end else begin
      soft_powerdown_ready_o <= (pd_q == PD_DOWN) && soft_powerdown_request_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // symbol rate enable and pattern counters

  logic [7:0] div_q;
  logic sym_en;
  logic [4:0] droop_q;
  logic alt_q;

  assign sym_en = (div_q == 8'h00);

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || div_q == 8'(SYM_DIVIDE - 1)) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || pd_q != PD_RUN) begin
      droop_q <= 5'h00;
      alt_q <= 1'b0;
    end else if (sym_en) begin
      alt_q <= ~alt_q;
      droop_q <= (droop_q == DROOP_LAST) ? 5'h00 : droop_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit symbol selection; only the symbol value differs per mode

  logic [1:0] sym_d;

  always_comb begin
    sym_d = pcs_tx_sym_i;
    case (mode_q)
      TM_ONE: sym_d = alt_q ? SYM_MINUS : SYM_PLUS;
      TM_TWO: sym_d = (droop_q < DROOP_RUN) ? SYM_PLUS : SYM_MINUS;
      TM_THREE: sym_d = pcs_idle_sym_i;
      default: sym_d = pcs_tx_sym_i;
    endcase
    if (txdis_q) begin
      sym_d = SYM_ZERO;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      tx_sym_o <= SYM_ZERO;
      tx_sym_stb_o <= 1'b0;
      tx_active_o <= 1'b0;
    end else begin
      tx_sym_stb_o <= sym_en && pd_q == PD_RUN;
      tx_active_o <= pd_q == PD_RUN;
      if (pd_q != PD_RUN) begin
        tx_sym_o <= SYM_ZERO;
      end else if (sym_en) begin
        tx_sym_o <= sym_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame generator, remote loopback and mac receive path

  logic gen_on;
  logic [7:0] gen_lfsr_q;
  logic [7:0] chk_lfsr_q;
  logic rx_dv_q;

  // without the diagnostic clock the generator has no clock, so it stays off
  assign gen_on = frame_gen_enable_i && diag_clock_enable_i;

  function automatic logic [7:0] lfsr_step(input logic [7:0] s);
    lfsr_step = s[0] ? ((s >> 1) ^ LFSR_TAPS) : (s >> 1);
  endfunction

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || !gen_on) begin
      gen_lfsr_q <= LFSR_SEED;
    end else begin
      gen_lfsr_q <= lfsr_step(gen_lfsr_q);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      line_tx_en_o <= 1'b0;
      line_txd_o <= 4'h0;
    end else if (remote_loopback_enable_i) begin
      line_tx_en_o <= line_rx_dv_i;
      line_txd_o <= line_rxd_i;
    end else if (gen_on) begin
      line_tx_en_o <= 1'b1;
      line_txd_o <= gen_lfsr_q[3:0];
    end else begin
      line_tx_en_o <= mac_tx_en_i;
      line_txd_o <= mac_txd_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || (remote_loopback_enable_i && remote_loopback_rx_suppress_i)) begin
      mac_rx_dv_o <= 1'b0;
      mac_rxd_o <= 4'h0;
    end else begin
      mac_rx_dv_o <= line_rx_dv_i;
      mac_rxd_o <= line_rxd_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame checker on looped-back line data

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rx_dv_q <= 1'b0;
      chk_lfsr_q <= LFSR_SEED;
      fc_frame_cnt_o <= 16'h0000;
      fc_err_cnt_o <= 16'h0000;
    end else begin
      rx_dv_q <= line_rx_dv_i;
      if (!frame_check_enable_i || !line_rx_dv_i) begin
        chk_lfsr_q <= LFSR_SEED;
      end else begin
        chk_lfsr_q <= lfsr_step(chk_lfsr_q);
        if (line_rxd_i != chk_lfsr_q[3:0]) begin
          fc_err_cnt_o <= fc_err_cnt_o + 16'h0001;
        end
      end
      if (frame_check_enable_i && rx_dv_q && !line_rx_dv_i) begin
        fc_frame_cnt_o <= fc_frame_cnt_o + 16'h0001;
      end
    end
  end

endmodule

//--- src/tx_test_pkg.sv
// constants for the transmit test pattern control block
package tx_test_pkg;
  // test mode control register field layout
  localparam int TM_SEL_HI = 15;
  localparam int TM_SEL_LO = 13;
  localparam logic [15:0] TM_CTRL_RESET = 16'h0000;
  localparam logic [15:0] TM_CTRL_MASK = 16'hE000;

  // test mode select encodings
  typedef enum logic [2:0] {
    TM_NORMAL = 3'b000,
    TM_ONE    = 3'b001,
    TM_TWO    = 3'b010,
    TM_THREE  = 3'b011
  } tm_sel_t;

  // ternary line symbols, two's complement
  localparam logic [1:0] SYM_PLUS = 2'b01;
  localparam logic [1:0] SYM_ZERO = 2'b00;
  localparam logic [1:0] SYM_MINUS = 2'b11;

  // droop pattern: run of equal symbols before the polarity flips
  localparam logic [4:0] DROOP_RUN = 5'h0A;
  localparam logic [4:0] DROOP_LAST = 5'h13;

  // 10BASE-T1L symbol rate 7.5 MBd from 200 MHz, rounded down
  localparam int CLK_MHZ = 200;
  localparam int SYM_KBD = 7500;
  localparam int SYM_DIV = (CLK_MHZ * 1000) / SYM_KBD;

  // power-down entry settle time in ns and cycles (least time, round up)
  localparam int PD_SETTLE_NS = 100;
  localparam int PD_SETTLE_CYC = (PD_SETTLE_NS * CLK_MHZ + 999) / 1000;

  // frame pattern lfsr
  localparam logic [7:0] LFSR_SEED = 8'hA5;
  localparam logic [7:0] LFSR_TAPS = 8'hB8;

  // power-down sequencer states
  typedef enum logic [1:0] {
    PD_RUN    = 2'b00,
    PD_ENTER  = 2'b01,
    PD_DOWN   = 2'b10
  } pd_state_t;
endpackage

//--- testbench/tx_test_checker.sv
// concurrent checks on the transmit test pattern control ports
`timescale 1ns/100ps
module tx_test_checker (
  // watched ports
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic tm_ctrl_wr_i,
  input wire logic [15:0] tm_ctrl_wdata_i,
  input wire logic [15:0] tm_ctrl_rdata_o,
  input wire logic soft_powerdown_request_i,
  input wire logic soft_powerdown_ready_o,
  input wire logic remote_loopback_enable_i,
  input wire logic remote_loopback_rx_suppress_i,
  input wire logic frame_gen_enable_i,
  input wire logic diag_clock_enable_i,
  input wire logic mac_tx_en_i,
  input wire logic [3:0] mac_txd_i,
  input wire logic mac_rx_dv_o,
  input wire logic line_rx_dv_i,
  input wire logic [3:0] line_rxd_i,
  input wire logic line_tx_en_o,
  input wire logic [3:0] line_txd_o,
  input wire logic tx_sym_stb_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_wr;
    tm_ctrl_wr_i ##1 !tm_ctrl_wr_i;
  endsequence
  sequence s_lb;
    remote_loopback_enable_i && remote_loopback_rx_suppress_i;
  endsequence
  property p_rdata;
    s_wr |=> tm_ctrl_rdata_o == ($past(tm_ctrl_wdata_i, 2) & 16'hE000);
  endproperty
  property p_rmask;
    tm_ctrl_rdata_o[12:0] == 13'h0000;
  endproperty
  property p_rdy_drop;
    !soft_powerdown_request_i |=> !soft_powerdown_ready_o;
  endproperty
  property p_rdy_cause;
    $rose(soft_powerdown_ready_o) |-> $past(soft_powerdown_request_i, 3);
  endproperty
  property p_pd_quiet;
    soft_powerdown_ready_o |-> !tx_sym_stb_o;
  endproperty
  property p_stb;
    tx_sym_stb_o |=> !tx_sym_stb_o;
  endproperty
  property p_supp;
    s_lb |=> !mac_rx_dv_o;
  endproperty
  property p_pass;
    !remote_loopback_enable_i |=> mac_rx_dv_o == $past(line_rx_dv_i);
  endproperty
  property p_loop;
    remote_loopback_enable_i |=> line_tx_en_o == $past(line_rx_dv_i) && line_txd_o == $past(line_rxd_i);
  endproperty
  // the generator only runs with the diagnostic clock on
  property p_gen;
    frame_gen_enable_i && diag_clock_enable_i && !remote_loopback_enable_i |=> line_tx_en_o;
  endproperty
  property p_mac;
    !frame_gen_enable_i && !remote_loopback_enable_i |=>
      line_tx_en_o == $past(mac_tx_en_i) && line_txd_o == $past(mac_txd_i);
  endproperty
  a_rdata: assert property (p_rdata) else $error("readback wrong");
  a_rmask: assert property (p_rmask) else $error("unused bits set");
  a_rdy_drop: assert property (p_rdy_drop) else $error("ready stuck");
  a_rdy_cause: assert property (p_rdy_cause) else $error("ready early");
  a_pd_quiet: assert property (p_pd_quiet) else $error("symbol in powerdown");
  a_stb: assert property (p_stb) else $error("strobe too long");
  a_supp: assert property (p_supp) else $error("rx not suppressed");
  a_pass: assert property (p_pass) else $error("rx not forwarded");
  a_loop: assert property (p_loop) else $error("loopback wrong");
  a_gen: assert property (p_gen) else $error("generator idle");
  a_mac: assert property (p_mac) else $error("mac data lost");
endmodule
bind tx_test_pattern_ctrl tx_test_checker i_chk (.*);

//--- testbench/link_partner.sv
// far phy with remote loopback: line frames come back after a delay
`timescale 1ns/100ps
module link_partner #(
  parameter int LAT = 2
) (
  // clock and fault injection
  input wire logic ref_clk_i,
  input wire logic corrupt_i,
  // cable
  input wire logic tx_en_i,
  input wire logic [3:0] txd_i,
  output logic rx_dv_o,
  output logic [3:0] rxd_o
);
  logic [4:0] pipe_q [LAT] = '{default: 5'h00};
  logic [3:0] junk_q = 4'h0;
  always_ff @(posedge ref_clk_i) begin
    pipe_q[0] <= {tx_en_i, txd_i ^ {4{corrupt_i & tx_en_i}}};
    for (int i = 1; i < LAT; i++) pipe_q[i] <= pipe_q[i-1];
    junk_q <= junk_q + 4'h5;
  end
  assign rx_dv_o = pipe_q[LAT-1][4];
  // outside frames the data lines carry a free-running count stepping by 5, not a held copy of the last nibble
  assign rxd_o = rx_dv_o ? pipe_q[LAT-1][3:0] : junk_q;
endmodule

//--- testbench/phy_tx_test_pattern_control_test.sv
// self-checking bench for the transmit test pattern control block
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t %h %h", $time, a, b); end end
module phy_tx_test_pattern_control_test;
  import tx_test_pkg::*;
  logic clk = 0, rst = 1, wr = 0, req = 0, an = 1, frc = 0, txdis = 0, cor = 0;
  logic lb = 0, sup = 1, diag = 0, gen = 0, fc = 0, mon = 0, mtx_en = 0, ready, mrx_dv, lrx_dv, ltx_en, stb, act;
  logic [15:0] wdata = 16'h0000, rdata, fcnt, ecnt;
  logic [3:0] mtxd = 4'h0, mrxd, lrxd, ltxd;
  logic [1:0] pcs = SYM_PLUS, idle = SYM_MINUS, sym;
  int n_errors = 0, n_checks = 0;
  int cfg[9] = '{1, 2, 3, 0, 4, 5, 7, 8, 10};
  // reference of the mac receive path: line data one cycle late, blanked under suppression
  logic [4:0] rx_q[$];
  tx_test_pattern_ctrl #(.SYM_DIVIDE(4), .PD_CYCLES(3)) i_dut (.ref_clk_i(clk), .sys_rst_i(rst),
    .tm_ctrl_wr_i(wr), .tm_ctrl_wdata_i(wdata), .tm_ctrl_rdata_o(rdata), .soft_powerdown_request_i(req),
    .soft_powerdown_ready_o(ready), .autoneg_enable_bit_i(an), .forced_link_enable_i(frc),
    .tx_disable_enable_i(txdis), .remote_loopback_enable_i(lb), .remote_loopback_rx_suppress_i(sup),
    .diag_clock_enable_i(diag), .frame_gen_enable_i(gen), .frame_check_enable_i(fc), .pcs_tx_sym_i(pcs),
    .pcs_idle_sym_i(idle), .mac_tx_en_i(mtx_en), .mac_txd_i(mtxd), .mac_rx_dv_o(mrx_dv), .mac_rxd_o(mrxd),
    .line_rx_dv_i(lrx_dv), .line_rxd_i(lrxd), .line_tx_en_o(ltx_en), .line_txd_o(ltxd), .tx_sym_o(sym),
    .tx_sym_stb_o(stb), .tx_active_o(act), .fc_frame_cnt_o(fcnt), .fc_err_cnt_o(ecnt));
  link_partner #(.LAT(3)) i_lp (.ref_clk_i(clk), .corrupt_i(cor), .tx_en_i(ltx_en), .txd_i(ltxd),
    .rx_dv_o(lrx_dv), .rxd_o(lrxd));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // compared on the falling edge, where outputs and inputs have settled
  always @(negedge clk) begin
    if (rst) begin
      rx_q.delete();
    end else begin
      if (rx_q.size() > 0) begin
        `CHK({mrx_dv, mrxd}, rx_q.pop_front())
      end
      rx_q.push_back((lb && sup) ? 5'h00 : {lrx_dv, lrxd});
    end
  end
  task automatic tick(int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      mtxd = 4'($urandom);
      mtx_en = mon & 1'($urandom);
    end
  endtask
  task automatic wr_reg(logic [15:0] v);
    wdata = v;
    wr = 1;
    tick(1);
    wr = 0;
    tick(2);
    `CHK(rdata, v & TM_CTRL_MASK)
  endtask
  // reference symbol for the k-th strobe after leaving power-down
  function automatic logic [1:0] exp_sym(int m, int td, int k);
    if (td) return SYM_ZERO;
    case (m)
      1: return k % 2 ? SYM_MINUS : SYM_PLUS;
      2: return (k / 10) % 2 ? SYM_MINUS : SYM_PLUS;
      3: return idle;
      default: return pcs;
    endcase
  endfunction
  task automatic run_mode(int m, int td);
    int k;
    req = 1;
    k = 0;
    while (!ready && k < 40) begin
      tick(1);
      k++;
    end
    `CHK(ready, 1'b1)
    `CHK(act, 1'b0)
    an = 0;
    frc = 1;
    txdis = td[0];
    wr_reg({m[2:0], 13'($urandom)});
    req = 0;
    for (int i = 0; i < 24; i++) begin
      k = 0;
      while (stb !== 1'b1 && k < 20) begin
        tick(1);
        k++;
      end
      `CHK(sym, exp_sym(m, td, i))
      `CHK(act, 1'b1)
      tick(1);
    end
    $display("mode %0d txdis %0d done", m, td);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    wrap_up();
  end
  initial begin
    void'($urandom(55));
    pcs = $urandom % 2 ? SYM_PLUS : SYM_MINUS;
    idle = pcs ^ 2'b10;
    tick(16);
    rst = 0;
    tick(2);
    foreach (cfg[i]) run_mode(cfg[i] & 7, cfg[i] >> 3);
    mon = 1;
    tick(30);
    lb = 1;
    tick(20);
    `CHK(mrx_dv, 1'b0)
    sup = 0;
    tick(20);
    lb = 0;
    mon = 0;
    $display("data path done");
    diag = 1;
    // let the loopback ring drain before the checker starts counting
    tick(10);
    fc = 1;
    gen = 1;
    tick(20);
    gen = 0;
    tick(20);
    `CHK(fcnt, 16'h0001)
    gen = 1;
    tick(5);
    cor = 1;
    tick(1);
    cor = 0;
    tick(14);
    gen = 0;
    tick(20);
    `CHK(fcnt, 16'h0002)
    `CHK(ecnt, 16'h0001)
    $display("link test done");
    wrap_up();
  end
endmodule
